// File: verif/pag_pins_model.sv
// Port A pin model: outside levels on every line the port releases
`timescale 1ns/100ps
`default_nettype none
module pag_pins_model
(
    input  wire logic [7:0] pa_out,
    input  wire logic [7:0] pa_oe,
    input  wire logic [7:0] ext_lvl,
    output var  logic [7:0] pa_in
);
    // Driven lines show the port level, released lines the outside level
    always_comb pa_in = (pa_out & pa_oe) | (ext_lvl & ~pa_oe);
endmodule
`default_nettype wire

// File: verif/tb_port_a_gpio_with_pin_steering.sv
// Self-checking bench for the port A block and its function steering
`timescale 1ns/100ps
`default_nettype none
module tb_port_a_gpio_with_pin_steering;
    import pag_pkg::*;
    logic sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, ext_v = 8'h00, pb_v = 8'h00;
    logic [7:0] reg_rdata, pa_in, pa_out, pa_oe, rv, d, l, a, w, m, pins;
    logic pa5_pullup, rxdt_in, spi1_sel_in, ccp2_in, ccp1_in, txck_in, dd;
    pag_ovr_s [7:0] pb_ovr;
    pag_ovr_s src [8] = '{default: PAG_OVR_NONE};
    int errors = 0, n_compared = 0, cyc = 0, on, off;
    // Function order: rx, spi out, mod2 B, capcomp2, mod1 D, mod1 C, capcomp1, tx
    int sbit [8] = '{7, 6, 4, 3, 2, 1, 0, 0};
    int pin0 [8] = '{1, 2, 7, 6, 7, 6, 3, 2};
    int pin1 [8] = '{2, 14, 14, 15, 14, 15, 0, 5};
    logic [7:0] rst_v [7] = '{8'hFF, 8'h00, 8'h1F, 8'h20, 8'h80, 8'h00, 8'h00};

    // Clock and hang guard
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            errors++;
            give_verdict();
        end
    end

    pag_port_a i_pag_port_a (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa5_pullup(pa5_pullup),
        .pb_in(pb_v), .pb_ovr(pb_ovr), .rxdt_src(src[0]), .spi1_out_src(src[1]),
        .mod2b_src(src[2]), .ccp2_src(src[3]), .mod1d_src(src[4]), .mod1c_src(src[5]),
        .ccp1_src(src[6]), .txck_src(src[7]), .rxdt_in(rxdt_in), .spi1_sel_in(spi1_sel_in),
        .ccp2_in(ccp2_in), .ccp1_in(ccp1_in), .txck_in(txck_in));
    pag_pins_model i_pag_pins_model (.pa_out(pa_out), .pa_oe(pa_oe), .ext_lvl(ext_v),
        .pa_in(pa_in));

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle register write and read strobes
    task automatic wr(logic [3:0] ad, logic [7:0] wd);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [3:0] ad, output logic [7:0] q);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask

    // Write strobe followed at once by a read strobe
    task automatic wr_rd(logic [3:0] wa, logic [7:0] wd, logic [3:0] ra, output logic [7:0] q);
        @(posedge sys_clk);
        reg_addr <= wa;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ra;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask

    task automatic idle(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Claim seen at a pin code: bit 3 set means port A
    function automatic logic [7:0] claim_of(int c);
        if (c > 7)
            return {5'h00, pa_oe[c-8], pa_oe[c-8], pa_oe[c-8] & pa_out[c-8]};
        return {5'h00, pb_ovr[c].en, pb_ovr[c].oe, pb_ovr[c].dat};
    endfunction

    function automatic logic in_of(int f);
        case (f)
            0: return rxdt_in;
            3: return ccp2_in;
            6: return ccp1_in;
            default: return txck_in;
        endcase
    endfunction

    function automatic logic lvl_of(int c, logic cd);
        return (c > 7) ? cd : pb_v[c];
    endfunction

    initial
    begin
        void'($urandom(53));
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        idle(1);
        chk("pullup after reset", 8'h00, {7'h00, pa5_pullup});
        for (int i = 0; i < 7; i++)
        begin
            rd(4'(i + 1), rv);
            chk("reset value", rst_v[i], rv);
        end
        ext_v <= 8'($urandom);
        idle(4);
        rd(PAG_ADR_PIN_VALUE, rv);
        chk("pins analog", ext_v & 8'hE0, rv);
        rd(4'hA, rv);
        chk("unmapped", 8'h00, rv);
        // Random direction, latch, analog and pin traffic
        for (int i = 0; i < 24; i++)
        begin
            d = 8'($urandom);
            l = 8'($urandom);
            a = 8'($urandom);
            w = 8'($urandom);
            ext_v <= 8'($urandom);
            wr(PAG_ADR_DIRECTION, d);
            wr(PAG_ADR_LATCH, l);
            wr(PAG_ADR_ANALOG, a);
            idle(3);
            m = ~(d | 8'h20);
            chk("pa_oe", m, pa_oe);
            chk("pa_out", l & m, pa_out & m);
            rd(PAG_ADR_DIRECTION, rv);
            chk("direction", d | 8'h20, rv);
            rd(PAG_ADR_LATCH, rv);
            chk("latch", l & 8'hDF, rv);
            pins = (l & m) | (ext_v & ~m);
            rd(PAG_ADR_PIN_VALUE, rv);
            chk("pin read", pins & ~(a & 8'h1F), rv);
            wr_rd(PAG_ADR_PIN_VALUE, w, PAG_ADR_LATCH, rv);
            chk("latch via pins", w & 8'hDF, rv);
            pins = ((w & m) | (ext_v & ~m)) & ~(a & 8'h1F);
            l = 8'($urandom);
            wr(i[0] ? PAG_ADR_PIN_SET : PAG_ADR_PIN_CLR, l);
            rd(PAG_ADR_LATCH, rv);
            chk("bit op", (i[0] ? (pins | l) : (pins & ~l)) & 8'hDF, rv);
        end
        rd(PAG_ADR_PIN_SET, rv);
        chk("bit op read", 8'h00, rv);
        // Pull-up on line 5 against control and global bits, all lines but input-only line 5 outputs
        wr(PAG_ADR_DIRECTION, 8'h00);
        wr(PAG_ADR_PULLUP, 8'hFF);
        wr(PAG_ADR_OPTION, 8'h00);
        idle(3);
        chk("pullup on", 8'h01, {7'h00, pa5_pullup});
        wr(PAG_ADR_OPTION, 8'h80);
        idle(3);
        chk("pullup global off", 8'h00, {7'h00, pa5_pullup});
        wr(PAG_ADR_OPTION, 8'h00);
        wr(PAG_ADR_PULLUP, 8'h00);
        idle(3);
        chk("pullup ctrl off", 8'h00, {7'h00, pa5_pullup});
        // Steering: every function on both of its pins; port A released
        wr(PAG_ADR_DIRECTION, 8'hFF);
        for (int f = 0; f < 8; f++)
            for (int s = 0; s < 2; s++)
            begin
                dd = 1'($urandom);
                pb_v <= 8'($urandom);
                wr(PAG_ADR_STEER0, (f < 7) ? 8'(s << sbit[f]) : 8'h00);
                wr(PAG_ADR_STEER1, (f == 7) ? 8'(s) : 8'h00);
                src[f] <= '{en: 1'b1, oe: 1'b1, dat: dd};
                idle(4);
                on = s ? pin1[f] : pin0[f];
                off = s ? pin0[f] : pin1[f];
                chk("claimed pin", {5'h00, 2'b11, dd}, claim_of(on));
                chk("released pin", 8'h00, claim_of(off));
                if (f == 0 || f == 3 || f == 6 || f == 7)
                    chk("steered input", {7'h00, lvl_of(on, dd)}, {7'h00, in_of(f)});
                src[f] <= PAG_OVR_NONE;
            end
        rd(PAG_ADR_DIRECTION, rv);
        chk("direction kept", 8'hFF, rv);
        idle(1);
        chk("read data cleared", 8'h00, reg_rdata);
        for (int s = 0; s < 2; s++)
        begin
            wr(PAG_ADR_STEER0, 8'(s << 5));
            idle(4);
            chk("select input", {7'h00, s ? ext_v[5] : pb_v[5]}, {7'h00, spi1_sel_in});
        end
        wr(PAG_ADR_STEER1, 8'hFF);
        rd(PAG_ADR_STEER1, rv);
        chk("steer1 bits", 8'h01, rv);
        // Reset in mid-run clears steering
        wr(PAG_ADR_STEER0, 8'hFF);
        nrst <= 1'b0;
        idle(2);
        nrst <= 1'b1;
        rd(PAG_ADR_STEER0, rv);
        chk("steer0 reset", 8'h00, rv);
        rd(PAG_ADR_STEER1, rv);
        chk("steer1 reset", 8'h00, rv);
        give_verdict();
    end
endmodule
`default_nettype wire

// File: verilog/pag_pkg.sv
// Shared constants and types for the port A pin block with function steering
package pag_pkg;

    // Register index on the plain register port
    localparam logic [3:0] PAG_ADR_PIN_VALUE = 4'h0;
    localparam logic [3:0] PAG_ADR_DIRECTION = 4'h1;
    localparam logic [3:0] PAG_ADR_LATCH     = 4'h2;
    localparam logic [3:0] PAG_ADR_ANALOG    = 4'h3;
    localparam logic [3:0] PAG_ADR_PULLUP    = 4'h4;
    localparam logic [3:0] PAG_ADR_OPTION    = 4'h5;
    localparam logic [3:0] PAG_ADR_STEER0    = 4'h6;
    localparam logic [3:0] PAG_ADR_STEER1    = 4'h7;
    localparam logic [3:0] PAG_ADR_PIN_SET   = 4'h8;
    localparam logic [3:0] PAG_ADR_PIN_CLR   = 4'h9;

    // Implemented bits per register
    localparam logic [7:0] PAG_LAT_MASK   = 8'hDF;
    localparam logic [7:0] PAG_ANA_MASK   = 8'h1F;
    localparam logic [7:0] PAG_PUP_MASK   = 8'h20;
    localparam logic [7:0] PAG_OPT_MASK   = 8'h80;
    localparam logic [7:0] PAG_STR1_MASK  = 8'h01;
    localparam logic [7:0] PAG_IN_ONLY    = 8'h20;

    // Reset values
    localparam logic [7:0] PAG_DIR_RST    = 8'hFF;
    localparam logic [7:0] PAG_LAT_RST    = 8'h00;
    localparam logic [7:0] PAG_ANA_RST    = 8'h1F;
    localparam logic [7:0] PAG_PUP_RST    = 8'h20;
    localparam logic [7:0] PAG_OPT_RST    = 8'h80;
    localparam logic [7:0] PAG_STR_RST    = 8'h00;

    // Field positions
    localparam int PAG_BIT_GPU_N      = 7;
    localparam int PAG_BIT_PUP5       = 5;
    localparam int PAG_BIT_RXDT       = 7;
    localparam int PAG_BIT_SPI1_OUT   = 6;
    localparam int PAG_BIT_SPI1_SEL   = 5;
    localparam int PAG_BIT_MOD2B      = 4;
    localparam int PAG_BIT_CCP2       = 3;
    localparam int PAG_BIT_MOD1D      = 2;
    localparam int PAG_BIT_MOD1C      = 1;
    localparam int PAG_BIT_CCP1       = 0;
    localparam int PAG_BIT_TXCK       = 0;

    // Peripheral claim on a pin: owns it, drives it, drive level
    typedef struct packed {
        logic en;
        logic oe;
        logic dat;
    } pag_ovr_s;

    localparam pag_ovr_s PAG_OVR_NONE = '{en: 1'b0, oe: 1'b0, dat: 1'b0};

endpackage

// File: verilog/pag_port_a.sv
// Port A pin control, register file and alternate function steering
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - An enabled peripheral owning a pin controls it instead of the port logic.
// - Port A is eight bits with direction and pin read each; all but line 5 are bidirectional with a latch.
// - Direction 1 turns the driver off; 0 drives the latch value onto the pin.
// - Line 5 is input only; its direction bit always reads 1.
// - Pin-value writes land in the latch; latch reads latch, pin-value reads pins.
// - Set and clear writes read the pins, modify, then store into the latch.
// - Analog select forces every digital read of that pin to 0.
// - Analog select leaves digital output untouched.
// - Direction still governs drivers on analog pins; software keeps them set.
// - Pull-up on line 5 follows pull-up control bit 5.
// - Pull-up is off whenever the pin is an output.
// - After reset the global pull-up enable holds pull-ups off.
// - Pin pull-up works only while the global pull-up enable bit is cleared.
// - Steering never changes direction bits; overrides follow the function's pin.
// - Steer0 bit 7 puts serial receive on port B line 1 or 2.
// - Steer0 bit 6 puts spi data out on port B line 2 or A line 6.
// - Steer0 bit 5 puts spi select on port B line 5 or A line 5.
// - Steer0 bit 4 puts modulator 2 output B on B line 7 or A line 6.
// - Steer0 bit 3 puts capture-compare 2 on B line 6 or A line 7.
// - Steer0 bit 2 puts modulator 1 output D on B line 7 or A line 6.
// - Steer0 bit 1 puts modulator 1 output C on B line 6 or A line 7.
// - Steer0 bit 0 puts capture-compare 1 on B line 3 or B line 0.
// - Steer1 bit 0 puts serial transmit on B line 2 or 5; bits 7-1 read 0.
module pag_port_a
#(
    parameter int ADDR_W = 4
)
(
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [7:0]        reg_rdata,
    input  wire logic [7:0]        pa_in,
    output var  logic [7:0]        pa_out,
    output var  logic [7:0]        pa_oe,
    output var  logic              pa5_pullup,
    input  wire logic [7:0]        pb_in,
    output var  pag_pkg::pag_ovr_s [7:0] pb_ovr,
    input  wire pag_pkg::pag_ovr_s rxdt_src,
    input  wire pag_pkg::pag_ovr_s spi1_out_src,
    input  wire pag_pkg::pag_ovr_s mod2b_src,
    input  wire pag_pkg::pag_ovr_s ccp2_src,
    input  wire pag_pkg::pag_ovr_s mod1d_src,
    input  wire pag_pkg::pag_ovr_s mod1c_src,
    input  wire pag_pkg::pag_ovr_s ccp1_src,
    input  wire pag_pkg::pag_ovr_s txck_src,
    output var  logic              rxdt_in,
    output var  logic              spi1_sel_in,
    output var  logic              ccp2_in,
    output var  logic              ccp1_in,
    output var  logic              txck_in
);
    import pag_pkg::*;

    // Address must reach every register index
    generate
        if (ADDR_W < 4)
        begin : g_chk
            $error("ADDR_W too narrow for the register map");
        end
    endgenerate

    logic [7:0]  dir_r;
    logic [7:0]  lat_r;
    logic [7:0]  ana_r;
    logic [7:0]  pup_r;
    logic [7:0]  opt_r;
    logic [7:0]  str0_r;
    logic [7:0]  str1_r;
    logic [7:0]  pin_rd;
    logic [7:0]  dir_rd;
    logic [7:0]  rdata_nxt;
    logic [3:0]  adr;
    logic        hit_wr;
    pag_ovr_s    ovr_a6;
    pag_ovr_s    ovr_a7;
    pag_ovr_s [7:0] pb_ovr_nxt;
    logic [7:0]  pa_out_nxt;
    logic [7:0]  pa_oe_nxt;

    // Claim passes only while its pin is the selected one
    function automatic pag_ovr_s route(input pag_ovr_s src, input logic sel);
        route = sel ? src : PAG_OVR_NONE;
    endfunction

    // Higher priority claim wins when it owns the pin
    function automatic pag_ovr_s pick(input pag_ovr_s hi, input pag_ovr_s lo);
        pick = hi.en ? hi : lo;
    endfunction

    assign adr    = reg_addr[3:0];
    assign hit_wr = reg_wr && (reg_addr >> 4) == '0;

    // Digital read path with analog pins forced low
    assign pin_rd = pa_in & ~ana_r;
    assign dir_rd = dir_r | PAG_IN_ONLY;

    // Direction register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            dir_r <= PAG_DIR_RST;
        else if (hit_wr && adr == PAG_ADR_DIRECTION)
            dir_r <= reg_wdata | PAG_IN_ONLY;
    end

    // Output latch: direct, pin-value, and pin-based set/clear writes
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            lat_r <= PAG_LAT_RST;
        else if (hit_wr)
        begin
            case (adr)
                PAG_ADR_LATCH,
                PAG_ADR_PIN_VALUE: lat_r <= reg_wdata & PAG_LAT_MASK;
                PAG_ADR_PIN_SET:   lat_r <= (pin_rd | reg_wdata) & PAG_LAT_MASK;
                PAG_ADR_PIN_CLR:   lat_r <= (pin_rd & ~reg_wdata) & PAG_LAT_MASK;
                default:           lat_r <= lat_r;
            endcase
        end
    end

    // Analog select, pull-up control and global pull-up enable
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ana_r <= PAG_ANA_RST;
            pup_r <= PAG_PUP_RST;
            opt_r <= PAG_OPT_RST;
        end
        else if (hit_wr)
        begin
            if (adr == PAG_ADR_ANALOG)
                ana_r <= reg_wdata & PAG_ANA_MASK;
            if (adr == PAG_ADR_PULLUP)
                pup_r <= reg_wdata & PAG_PUP_MASK;
            if (adr == PAG_ADR_OPTION)
                opt_r <= reg_wdata & PAG_OPT_MASK;
        end
    end

    // Steering selects, cleared on every reset
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            str0_r <= PAG_STR_RST;
            str1_r <= PAG_STR_RST;
        end
        else if (hit_wr)
        begin
            if (adr == PAG_ADR_STEER0)
                str0_r <= reg_wdata;
            if (adr == PAG_ADR_STEER1)
                str1_r <= reg_wdata & PAG_STR1_MASK;
        end
    end

    // Read mux; unmapped or write-only indices return zero
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_rd && (reg_addr >> 4) == '0)
        begin
            case (adr)
                PAG_ADR_PIN_VALUE: rdata_nxt = pin_rd;
                PAG_ADR_DIRECTION: rdata_nxt = dir_rd;
                PAG_ADR_LATCH:     rdata_nxt = lat_r;
                PAG_ADR_ANALOG:    rdata_nxt = ana_r;
                PAG_ADR_PULLUP:    rdata_nxt = pup_r;
                PAG_ADR_OPTION:    rdata_nxt = opt_r;
                PAG_ADR_STEER0:    rdata_nxt = str0_r;
                PAG_ADR_STEER1:    rdata_nxt = str1_r;
                default:           rdata_nxt = 8'h00;
            endcase
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rdata_nxt;
    end

    // Port A claims in output priority order
    always_comb
    begin
        ovr_a6 = pick(route(spi1_out_src, str0_r[PAG_BIT_SPI1_OUT]),
                 pick(route(mod1d_src, str0_r[PAG_BIT_MOD1D]),
                      route(mod2b_src, str0_r[PAG_BIT_MOD2B])));
        ovr_a7 = pick(route(mod1c_src, str0_r[PAG_BIT_MOD1C]),
                      route(ccp2_src, str0_r[PAG_BIT_CCP2]));
    end

    // Port B claims for the port B pin logic
    always_comb
    begin
        pb_ovr_nxt    = {8{PAG_OVR_NONE}};
        pb_ovr_nxt[0] = route(ccp1_src, str0_r[PAG_BIT_CCP1]);
        pb_ovr_nxt[1] = route(rxdt_src, !str0_r[PAG_BIT_RXDT]);
        pb_ovr_nxt[2] = pick(route(rxdt_src, str0_r[PAG_BIT_RXDT]),
                        pick(route(txck_src, !str1_r[PAG_BIT_TXCK]),
                             route(spi1_out_src, !str0_r[PAG_BIT_SPI1_OUT])));
        pb_ovr_nxt[3] = route(ccp1_src, !str0_r[PAG_BIT_CCP1]);
        pb_ovr_nxt[5] = route(txck_src, str1_r[PAG_BIT_TXCK]);
        pb_ovr_nxt[6] = pick(route(mod1c_src, !str0_r[PAG_BIT_MOD1C]),
                             route(ccp2_src, !str0_r[PAG_BIT_CCP2]));
        pb_ovr_nxt[7] = pick(route(mod1d_src, !str0_r[PAG_BIT_MOD1D]),
                             route(mod2b_src, !str0_r[PAG_BIT_MOD2B]));
    end

    // Pin drivers: peripheral claim first, else direction and latch
    always_comb
    begin
        pa_oe_nxt  = ~dir_rd;
        pa_out_nxt = lat_r;
        if (ovr_a6.en)
        begin
            pa_oe_nxt[6]  = ovr_a6.oe;
            pa_out_nxt[6] = ovr_a6.dat;
        end
        if (ovr_a7.en)
        begin
            pa_oe_nxt[7]  = ovr_a7.oe;
            pa_out_nxt[7] = ovr_a7.dat;
        end
    end

    // Registered pin outputs and port B claims
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pa_out <= 8'h00;
            pa_oe  <= 8'h00;
            pb_ovr <= {8{PAG_OVR_NONE}};
        end
        else
        begin
            pa_out <= pa_out_nxt;
            pa_oe  <= pa_oe_nxt;
            pb_ovr <= pb_ovr_nxt;
        end
    end

    // Weak pull-up on line 5
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            pa5_pullup <= 1'b0;
        else
            pa5_pullup <= pup_r[PAG_BIT_PUP5]
                        && !opt_r[PAG_BIT_GPU_N]
                        && !pa_oe_nxt[5];
    end

    // Pin levels delivered to the steered peripheral inputs
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rxdt_in <= 1'b0;
            spi1_sel_in <= 1'b0;
            ccp2_in <= 1'b0;
            ccp1_in <= 1'b0;
            txck_in <= 1'b0;
        end
        else
        begin
            rxdt_in <= str0_r[PAG_BIT_RXDT] ? pb_in[2] : pb_in[1];
            spi1_sel_in <= str0_r[PAG_BIT_SPI1_SEL] ? pin_rd[5] : pb_in[5];
            ccp2_in <= str0_r[PAG_BIT_CCP2] ? pin_rd[7] : pb_in[6];
            ccp1_in <= str0_r[PAG_BIT_CCP1] ? pb_in[0] : pb_in[3];
            txck_in <= str1_r[PAG_BIT_TXCK] ? pb_in[5] : pb_in[2];
        end
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    sequence rd_of(logic [3:0] a);
        reg_rd && (reg_addr >> 4) == '0 && adr == a;
    endsequence

    sequence wr_of(logic [3:0] a);
        hit_wr && adr == a;
    endsequence

    dir_bit_five_a: assert property (rd_of(PAG_ADR_DIRECTION) |=> reg_rdata[5])
        else $error("line 5 direction did not read as 1");

    pin_read_a: assert property (rd_of(PAG_ADR_PIN_VALUE)
        |=> reg_rdata == ($past(pa_in) & ~$past(ana_r)))
        else $error("pin read did not mask analog pins");

    pin_write_latch_a: assert property (wr_of(PAG_ADR_PIN_VALUE)
        ##1 rd_of(PAG_ADR_LATCH) |=> reg_rdata == ($past(reg_wdata, 2) & PAG_LAT_MASK))
        else $error("pin-value write did not reach the latch");

    pin_set_rmw_a: assert property (wr_of(PAG_ADR_PIN_SET)
        |=> lat_r == (($past(pin_rd) | $past(reg_wdata)) & PAG_LAT_MASK))
        else $error("set write did not start from pin levels");

    drive_line0_a: assert property (!dir_r[0] |=> pa_oe[0] && pa_out[0] == $past(lat_r[0]))
        else $error("line 0 not driven from latch");

    analog_drive_a: assert property (ana_r[1] && dir_r[1] |=> !pa_oe[1])
        else $error("analog pin with direction set is driven");

    analog_out_a: assert property (ana_r[2] && !dir_r[2] |=> pa_oe[2])
        else $error("analog select blocked digital output");

    pullup_gate_a: assert property (pa5_pullup |-> $past(!opt_r[7] && pup_r[5]))
        else $error("pull-up on without both enables");

    steer_keeps_dir_a: assert property (wr_of(PAG_ADR_STEER0) |=> $stable(dir_r))
        else $error("steering write changed direction");

    spi_out_a6_a: assert property (str0_r[6] && spi1_out_src.en
        |=> pa_oe[6] == $past(spi1_out_src.oe) && pa_out[6] == $past(spi1_out_src.dat))
        else $error("spi data out not on line 6");

    select_route_a: assert property (str0_r[5] |=> spi1_sel_in == $past(pin_rd[5]))
        else $error("spi select not taken from line 5");

    steer1_read_a: assert property (rd_of(PAG_ADR_STEER1) |=> reg_rdata[7:1] == 7'h00)
        else $error("steer1 upper bits not zero");

    // Read data, line 5, latch stores, steered claims and the steered receive input
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data stood past its cycle");

    line5_undriven_a: assert property (!pa_oe[5])
        else $error("input-only line 5 driven");

    pullup_off_out_a: assert property (pa5_pullup |-> !pa_oe[5])
        else $error("pull-up on while line 5 drives");

    latch_write_a: assert property (wr_of(PAG_ADR_LATCH)
        |=> lat_r == ($past(reg_wdata) & PAG_LAT_MASK))
        else $error("latch write not stored");

    pin_clr_rmw_a: assert property (wr_of(PAG_ADR_PIN_CLR)
        |=> lat_r == ($past(pin_rd) & ~$past(reg_wdata) & PAG_LAT_MASK))
        else $error("clear write did not start from pin levels");

    rx_route_b1_a: assert property (!str0_r[PAG_BIT_RXDT]
        |=> pb_ovr[1] == $past(rxdt_src))
        else $error("serial receive claim not on port B line 1");

    rx_input_b2_a: assert property (str0_r[PAG_BIT_RXDT]
        |=> rxdt_in == $past(pb_in[2]))
        else $error("serial receive input not taken from port B line 2");

    ccp1_route_b0_a: assert property (str0_r[PAG_BIT_CCP1]
        |=> pb_ovr[0] == $past(ccp1_src) && pb_ovr[3] == PAG_OVR_NONE)
        else $error("capture-compare 1 claim not on port B line 0 only");

    tx_route_b5_a: assert property (str1_r[PAG_BIT_TXCK]
        |=> pb_ovr[5] == $past(txck_src))
        else $error("serial transmit claim not on port B line 5");

    owner_line6_a: assert property (ovr_a6.en
        |=> pa_oe[6] == $past(ovr_a6.oe) && pa_out[6] == $past(ovr_a6.dat))
        else $error("owning peripheral lost line 6");

endmodule

`default_nettype wire
